// >>> bench/idew_chk_sva.sv
`timescale 1ns/1ps
module idew_chk
   import idew_pkg::*;
(
   // Watched ports
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          online_mode,
   input  wire logic          reg_rd,
   input  wire logic          host_ack,
   input  wire logic [5:0]    rt_start,
   input  wire logic [7:0]    reg_rdata,
   input  wire idew_msg_t     host_msg,
   input  wire idew_readout_t readout,
   input  wire logic          pattern_start
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_load;
      $rose(readout.valid);
   endsequence
   sequence s_pat;
      ##[0:2] pattern_start;
   endsequence
   a_start_onehot: assert property ($onehot0(rt_start))
      else $error("routine starts overlap");
   a_start_gap: assert property (|rt_start |=> rt_start == 6'h00)
      else $error("routine start not a pulse");
   a_msg_hold: assert property (host_msg.valid && !host_ack
      |=> host_msg.valid && $stable(host_msg.word))
      else $error("host message dropped early");
   a_msg_bits: assert property (host_msg.valid
      |-> host_msg.word[7:6] == 2'b00)
      else $error("unused word bits set");
   a_no_msg: assert property (!online_mode |-> !host_msg.valid)
      else $error("message sent in standalone mode");
   a_readout_form: assert property (readout.valid
      |-> readout.test_mark && readout.upper == 3'h0)
      else $error("readout form wrong");
   a_pattern_follow: assert property (s_load |-> s_pat)
      else $error("pattern did not start");
   a_pattern_pulse: assert property (pattern_start
      |=> !pattern_start)
      else $error("pattern start not a pulse");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without read");
endmodule
bind idew_top idew_chk i_chk (.core_clk(core_clk), .rst(rst),
   .online_mode(online_mode), .reg_rd(reg_rd), .host_ack(host_ack),
   .rt_start(rt_start), .reg_rdata(reg_rdata), .host_msg(host_msg),
   .readout(readout), .pattern_start(pattern_start));

// >>> bench/idew_host_model.sv
`timescale 1ns/1ps
module idew_host_model
   import idew_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Message link
   input  wire idew_msg_t  host_msg,
   input  wire logic [3:0] ack_dly,
   output logic            host_ack,
   // Capture
   output logic [7:0]      last_word,
   output logic [7:0]      n_msgs
);
   logic [3:0] wait_r;
   // Takes a message after a programmable stall.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         host_ack  <= 1'b0;
         wait_r    <= 4'h0;
         last_word <= 8'h00;
         n_msgs    <= 8'h00;
      end
      else if (host_ack)
      begin
         host_ack <= 1'b0;
         wait_r   <= 4'h0;
      end
      else if (host_msg.valid)
      begin
         if (wait_r >= ack_dly)
         begin
            host_ack  <= 1'b1;
            last_word <= host_msg.word;
            n_msgs    <= n_msgs + 8'h01;
         end
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
   import idew_pkg::*;
();
   logic core_clk, rst, init_req, online_mode, reg_wr, reg_rd, host_ack;
   logic pattern_start, irq;
   logic [5:0] rt_start, rt_done, rt_fail, card_present, fail_mask, st1;
   logic [5:0] hang_mask;
   logic [1:0] serial_chk, mem_chk, conv_chk;
   logic [2:0] parallel_chk;
   logic [4:0] proc_chk;
   logic [3:0] disp_chk, reg_addr, ack_dly;
   logic [7:0] reg_wdata, reg_rdata, last_word, n_msgs, rv;
   idew_msg_t     host_msg;
   idew_readout_t readout;
   int            miscompares;
   int            n_compared;
   idew_top i_dut (.core_clk(core_clk), .rst(rst), .init_req(init_req),
      .online_mode(online_mode), .rt_start(rt_start), .rt_done(rt_done),
      .rt_fail(rt_fail), .serial_chk(serial_chk), .parallel_chk(parallel_chk),
      .proc_chk(proc_chk), .mem_chk(mem_chk), .disp_chk(disp_chk),
      .conv_chk(conv_chk), .card_present(card_present), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .host_msg(host_msg), .host_ack(host_ack),
      .readout(readout), .pattern_start(pattern_start), .irq(irq));
   idew_host_model i_host (.core_clk(core_clk), .rst(rst),
      .host_msg(host_msg), .ack_dly(ack_dly), .host_ack(host_ack),
      .last_word(last_word), .n_msgs(n_msgs));
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Routine engines answer two cycles after each start unless held.
   always @(posedge core_clk)
   begin
      st1     <= rt_start;
      rt_done <= st1 & ~hang_mask;
      rt_fail <= st1 & fail_mask;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (miscompares == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rv = reg_rdata;
   endtask
   task automatic run(input logic on, input logic [5:0] fm,
                      input logic [5:0] pres, input logic [7:0] exp,
                      input logic by_reg);
      int         i;
      logic [7:0] n0;
      n0 = n_msgs;
      @(posedge core_clk);
      online_mode <= on; fail_mask <= fm; card_present <= pres;
      if (by_reg)
         wr(OFF_CTRL, 8'h01);
      else
      begin
         @(posedge core_clk);
         init_req <= 1'b1;
         @(posedge core_clk);
         init_req <= 1'b0;
      end
      i = 0;
      while ((on ? n_msgs == n0 : pattern_start !== 1'b1) && i < 20000)
      begin
         @(negedge core_clk);
         i++;
      end
      if (i == 20000)
      begin
         miscompares++;
         results();
      end
      rd(OFF_ERROR);
      chk(rv, exp);
      if (on)
         chk(last_word, exp);
      else
      begin
         chk({readout.upper[1:0], readout.middle, readout.lower},
             exp);
         chk({7'h00, readout.test_mark}, 8'h01);
      end
   endtask
   task automatic t_mixed;
      run(1'b0, 6'h05, 6'h1f, 8'h25, 1'b0);
   endtask
   task automatic t_clean;
      run(1'b0, 6'h00, 6'h3f, 8'h00, 1'b0);
   endtask
   task automatic t_each;
      for (int k = 0; k < 6; k++)
      begin
         ack_dly = 4'(k);
         run(1'b1, 6'h01 << k, 6'h3f, 8'h01 << k, 1'b0);
      end
   endtask
   task automatic t_subchk;
      @(posedge core_clk);
      serial_chk <= 2'h1; parallel_chk <= 3'h5; proc_chk <= 5'h1b;
      mem_chk <= 2'h2; disp_chk <= 4'h7; conv_chk <= 2'h1;
      run(1'b1, 6'h00, 6'h3f, 8'h3f, 1'b0);
      @(posedge core_clk);
      serial_chk <= 2'h3; parallel_chk <= 3'h7; proc_chk <= 5'h1f;
      mem_chk <= 2'h3; disp_chk <= 4'hf; conv_chk <= 2'h3;
   endtask
   task automatic t_timeout;
      @(posedge core_clk);
      hang_mask <= 6'h10;
      run(1'b0, 6'h00, 6'h3f, 8'h10, 1'b0);
      hang_mask <= 6'h00;
   endtask
   task automatic t_irq;
      rd(OFF_STATUS);
      chk(rv, 8'h28);
      wr(OFF_CTRL, 8'h02);
      rd(OFF_CTRL);
      chk(rv, 8'h02);
      rd(OFF_IRQ_ST);
      chk(rv, 8'h03);
      chk({7'h00, irq}, 8'h00);
      wr(OFF_IRQ_MK, 8'h03);
      chk({7'h00, irq}, 8'h01);
      wr(OFF_IRQ_ST, 8'h03);
      chk({7'h00, irq}, 8'h00);
      rd(4'hf);
      chk(rv, 8'h00);
      rd(OFF_PRES);
      chk(rv, 8'h3f);
   endtask
   task automatic t_regstart;
      wr(OFF_PRES, 8'h3e);
      run(1'b0, 6'h00, 6'h3f, 8'h01, 1'b1);
   endtask
   initial
   begin
      rst = 1'b1; init_req = 1'b0; online_mode = 1'b0; ack_dly = 4'h0;
      reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
      fail_mask = 6'h00; card_present = 6'h3f; hang_mask = 6'h00;
      serial_chk = 2'h3;
      parallel_chk = 3'h7; proc_chk = 5'h1f; mem_chk = 2'h3;
      disp_chk = 4'hf; conv_chk = 2'h3; miscompares = 0; n_compared = 0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      t_mixed();
      t_clean();
      t_each();
      t_subchk();
      t_timeout();
      t_irq();
      t_regstart();
      results();
   end
endmodule

// >>> core/idew_readout.sv
`timescale 1ns/1ps
module idew_readout
   import idew_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // Result input
   input  wire logic          load,
   input  wire logic [7:0]    word,
   // Readout
   output idew_readout_t      readout
);

   // ----------------------------------------
   // Octal readout register
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         readout <= '0;
      end
      else if (load)
      begin
         // [RULE9] octal digit grouping
         readout.upper     <= {1'b0, word[7:6]};
         readout.middle    <= word[5:3];
         readout.lower     <= word[2:0];
         // [RULE3] test indicator mark
         readout.test_mark <= 1'b1;
         readout.valid     <= 1'b1;
      end
   end

endmodule

// >>> core/idew_top.sv
// Contract
// [RULE1] Each initialization runs all card routines and records go or no-go.
// [RULE2] Online: failed routine sets its bit; word is sent to host.
// [RULE3] Standalone: show octal readout with test mark, then start pattern; code loads both on the same edge.
// [RULE4] Eight-bit word; bits 0..5 name routines; bits 6 and 7 unused.
// [RULE5] Routine bit is one on error, zero on pass.
// [RULE6] Absent card counts as a failed routine.
// [RULE7] All cards present and passing gives readout 000.
// [RULE8] Several failures are combined into one reported value.
// [RULE9] Digits are bits 7..6, 5..3 and 2..0.
// [RULE10] Result names only the failed routine, no failure detail.
// [RULE11] Serial routine passes only if its status registers are initialized.
// [RULE12] Parallel routine needs handshake and status registers initialized.
// [RULE13] Processor routine checks branch, interrupt, one-, two-, three-word ops.
// [RULE14] Memory routine saves, tests and restores every location.
// [RULE15] Display routine checks registers, generators, refresh, controller cycle.
// [RULE16] Converter routine writes a simple instruction and sees it execute.
// [RULE17] Error word is cleared at the start of every initialization.
// [RULE18] Routines run in fixed order, each finishing before the next.
`timescale 1ns/1ps
module idew_top
   import idew_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // Initialization request and mode
   input  wire logic          init_req,
   input  wire logic          online_mode,
   // Routine engines
   output logic [5:0]         rt_start,
   input  wire logic [5:0]    rt_done,
   input  wire logic [5:0]    rt_fail,
   // Per-routine sub-check results
   input  wire logic [1:0]    serial_chk,
   input  wire logic [2:0]    parallel_chk,
   input  wire logic [4:0]    proc_chk,
   input  wire logic [1:0]    mem_chk,
   input  wire logic [3:0]    disp_chk,
   input  wire logic [1:0]    conv_chk,
   // Card presence
   input  wire logic [5:0]    card_present,
   // Register port
   input  wire logic [3:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [7:0]         reg_rdata,
   // Host message and readout
   output idew_msg_t          host_msg,
   input  wire logic          host_ack,
   output idew_readout_t      readout,
   output logic               pattern_start,
   // Interrupt
   output logic               irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   idew_state_t  state_r;
   logic [2:0]   idx_r;
   logic [7:0]   err_r;
   logic [16:0]  tmo_r;
   logic         busy_r;
   logic [1:0]   irq_st_r;
   logic [1:0]   irq_mk_r;
   logic [1:0]   ctrl_r;
   logic [5:0]   pres_mask_r;
   logic         launch_req;
   logic         rt_fail_now;
   logic         rt_end;
   logic         ev_done;
   logic         ev_fail;
   logic         load_ro;
   logic         ctrl_wr;
   logic         irq_st_wr;
   logic         irq_mk_wr;
   logic         pres_wr;
   logic [1:0]   irq_clr;
   logic         run_start;
   logic         tmo_zero;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [5:0] onehot6(input logic [2:0] i);
      logic [5:0] v;
      v = 6'h00;
      v[i] = 1'b1;
      return v;
   endfunction

   function automatic logic sub_fail(input logic [2:0] i,
                                     input logic [1:0] s,
                                     input logic [2:0] p,
                                     input logic [4:0] d,
                                     input logic [1:0] m,
                                     input logic [3:0] g,
                                     input logic [1:0] c);
      logic f;
      f = 1'b0;
      case (i)
         // [RULE15] display generator checks
         3'h0: f = ~&g;
         // [RULE13] processor instruction checks
         3'h1: f = ~&d;
         // [RULE14] save, test, restore
         3'h2: f = ~&m;
         // [RULE11] serial status initialized
         3'h3: f = ~&s;
         // [RULE12] handshake and status
         3'h4: f = ~&p;
         // [RULE16] converter instruction runs
         3'h5: f = ~&c;
         default: f = 1'b1;
      endcase
      return f;
   endfunction

   function automatic logic wr_hit(input logic       wr,
                                   input logic [3:0] a,
                                   input logic [3:0] off);
      return wr && (a == off);
   endfunction

   // ----------------------------------------
   // Register write decode
   // ----------------------------------------
   assign ctrl_wr   = wr_hit(reg_wr, reg_addr, OFF_CTRL);
   assign irq_st_wr = wr_hit(reg_wr, reg_addr, OFF_IRQ_ST);
   assign irq_mk_wr = wr_hit(reg_wr, reg_addr, OFF_IRQ_MK);
   assign pres_wr   = wr_hit(reg_wr, reg_addr, OFF_PRES);
   assign irq_clr   = irq_st_wr ? reg_wdata[1:0] : 2'h0;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   assign launch_req = init_req | (ctrl_wr && reg_wdata[CTRL_START]);
   assign run_start  = launch_req
                       && (state_r == ST_IDLE || state_r == ST_DONE);
   assign tmo_zero   = (tmo_r == 17'h0_0000);
   // [RULE6] absent card fails
   assign rt_fail_now = ~card_present[idx_r] | ~pres_mask_r[idx_r]
                        | rt_fail[idx_r]
                        | sub_fail(idx_r, serial_chk, parallel_chk,
                                   proc_chk, mem_chk, disp_chk, conv_chk);
   assign rt_end = (state_r == ST_WAIT)
                   && (rt_done[idx_r] || tmo_zero
                       || !card_present[idx_r]);

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         idx_r   <= 3'h0;
         busy_r  <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_IDLE, ST_DONE:
            begin
               // [RULE1] start full set
               if (launch_req)
               begin
                  state_r <= ST_LAUNCH;
                  idx_r   <= 3'h0;
                  busy_r  <= 1'b1;
               end
            end
            ST_LAUNCH:
               state_r <= ST_WAIT;
            ST_WAIT:
            begin
               // [RULE18] one routine at a time
               if (rt_end)
               begin
                  // [RULE8] continue after failures
                  if (idx_r == LAST_IDX)
                     state_r <= ST_REPORT;
                  else
                  begin
                     idx_r   <= idx_r + 3'h1;
                     state_r <= ST_LAUNCH;
                  end
               end
            end
            ST_REPORT:
            begin
               if (!online_mode || host_ack)
               begin
                  state_r <= ST_DONE;
                  busy_r  <= 1'b0;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Routine start and timeout
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         rt_start <= 6'h00;
      else if (state_r == ST_LAUNCH)
         rt_start <= onehot6(idx_r);
      else
         rt_start <= 6'h00;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         tmo_r <= 17'h0_0000;
      else if (state_r == ST_LAUNCH)
         tmo_r <= 17'(ROUTINE_TMO_CYC);
      else if (state_r == ST_WAIT && tmo_r != 17'h0_0000)
         tmo_r <= tmo_r - 17'h0_0001;
   end

   // ----------------------------------------
   // Error word
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         err_r <= ERR_RESET;
      // [RULE17] clear at start
      else if (run_start)
         err_r <= ERR_RESET;
      else if (rt_end)
      begin
         // [RULE5] one on error, zero on pass
         // [RULE4] bits 6 and 7 stay zero
         err_r[idx_r] <= rt_fail_now | tmo_zero;
      end
   end

   // ----------------------------------------
   // Host message and readout
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         host_msg <= '0;
      // [RULE2] send word to host
      // [RULE10] word only, no detail
      else if (state_r == ST_REPORT && online_mode && !host_ack)
      begin
         host_msg.valid <= 1'b1;
         host_msg.word  <= err_r;
      end
      else
         host_msg.valid <= 1'b0;
   end

   // [RULE3] readout and pattern start both load on the same edge
   // [RULE7] passing word shows 000
   assign load_ro = (state_r == ST_REPORT) && !online_mode;

   idew_readout u_readout
   (
      .core_clk (core_clk),
      .rst      (rst),
      .load     (load_ro),
      .word     (err_r),
      .readout  (readout)
   );

   always_ff @(posedge core_clk)
   begin
      if (rst)
         pattern_start <= 1'b0;
      else
         pattern_start <= load_ro;
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign ev_done = (state_r == ST_REPORT) && (!online_mode || host_ack);
   assign ev_fail = ev_done && (err_r != 8'h00);

   always_ff @(posedge core_clk)
   begin
      if (rst)
         irq_st_r <= IRQ_RESET;
      else
         irq_st_r <= (irq_st_r & ~irq_clr) | {ev_fail, ev_done};
   end

   assign irq = |(irq_st_r & irq_mk_r);

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // [RULE1] software start bit
   always_ff @(posedge core_clk)
   begin
      if (rst)
         ctrl_r <= 2'h0;
      else if (ctrl_wr)
         ctrl_r <= {reg_wdata[CTRL_ONLINE], 1'b0};
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         irq_mk_r <= IRQ_RESET;
      else if (irq_mk_wr)
         irq_mk_r <= reg_wdata[1:0];
   end

   // [RULE6] presence mask
   always_ff @(posedge core_clk)
   begin
      if (rst)
         pres_mask_r <= PRES_RESET;
      else if (pres_wr)
         pres_mask_r <= reg_wdata[5:0];
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            OFF_CTRL:   reg_rdata <= {6'h00, ctrl_r};
            OFF_STATUS: reg_rdata <= {2'h0, idx_r, 2'h0, busy_r};
            OFF_ERROR:  reg_rdata <= err_r;
            OFF_IRQ_ST: reg_rdata <= {6'h00, irq_st_r};
            OFF_IRQ_MK: reg_rdata <= {6'h00, irq_mk_r};
            OFF_PRES:   reg_rdata <= {2'h0, pres_mask_r};
            default:    reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

endmodule

// >>> inc/idew_pkg.sv
package idew_pkg;

   // ----------------------------------------
   // Error word layout
   // ----------------------------------------
   localparam int ERR_W            = 8;
   localparam int BIT_GRAPHIC      = 0;
   localparam int BIT_DISP_PROC    = 1;
   localparam int BIT_MEMORY       = 2;
   localparam int BIT_SERIAL       = 3;
   localparam int BIT_PARALLEL     = 4;
   localparam int BIT_CONV3D       = 5;
   localparam int NUM_ROUTINES     = 6;
   localparam logic [7:0] ERR_RESET = 8'h00;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h1;
   localparam logic [3:0] OFF_ERROR  = 4'h2;
   localparam logic [3:0] OFF_IRQ_ST = 4'h3;
   localparam logic [3:0] OFF_IRQ_MK = 4'h4;
   localparam logic [3:0] OFF_PRES   = 4'h5;

   localparam int CTRL_START  = 0;
   localparam int CTRL_ONLINE = 1;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_FAIL    = 1;

   localparam logic [5:0] PRES_RESET = 6'h3f;
   localparam logic [1:0] IRQ_RESET  = 2'h0;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ         = 125;
   localparam int ROUTINE_TMO_US  = 100;
   localparam int ROUTINE_TMO_CYC = ROUTINE_TMO_US * CLK_MHZ;
   localparam logic [2:0] LAST_IDX = 3'h5;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [4:0]
   {
      ST_IDLE   = 5'b00001,
      ST_LAUNCH = 5'b00010,
      ST_WAIT   = 5'b00100,
      ST_REPORT = 5'b01000,
      ST_DONE   = 5'b10000
   } idew_state_t;

   typedef struct packed
   {
      logic       valid;
      logic [7:0] word;
   } idew_msg_t;

   typedef struct packed
   {
      logic       valid;
      logic [2:0] upper;
      logic [2:0] middle;
      logic [2:0] lower;
      logic       test_mark;
   } idew_readout_t;

endpackage
